// *** hw/host_port_pin_and_bus_config.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Multiplexed mode: select only when address bits 10..3 (latched bits 7..3, live pins 10..8) equal base.
// - Base register bits 15..8 always read zero.
// - General-pin enable off: general pins float and their inputs read zero.
// - Multiplexed mode: address-8 pin is address 8 or general, per bit 1.
// - Multiplexed mode: address-9 pin is address 9 or general, per bit 2.
// - Bit 3 set: select pin is chip select or address 10; clear: general.
// - Request enable drives combined request, or separate transmit and receive requests.
// - Single-request mode: acknowledge input needs both ack and request enables.
// - Port enable off: every pin is general-purpose, interface inactive.
// - Port control bit 7 always reads zero.
// - Request outputs push-pull with bit 8 clear, open-drain with it set.
// - Data strobes active low with bit 9 clear, active high when set.
// - Address sampled while address strobe is at its active level.
// - Bit 11 set: register address from address latch, else from pins.
// - Bit 12 clear: one strobe plus read/write line; set: separate strobes.
// - Chip select polarity from bit 13, ignored in multiplexed mode.
// - Request outputs active low with bit 14 clear, active high when set.
// - Interrupt vector driven on data pins while acknowledge is active.
// - Direction bit set makes a general pin an output, clear an input.
// - Clearing port enable resets the interface state.
module host_port_pin_and_bus_config
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Core register port
  input  wire logic [23:0] core_addr,
  input  wire logic        core_wr,
  input  wire logic        core_rd,
  input  wire logic [15:0] core_wdata,
  output logic [15:0]      core_rdata,
  // Port pins
  input  wire logic [15:0] pin_in,
  output logic [15:0]      pin_out,
  output logic [15:0]      pin_oe_n,
  // Interface logic requests and data
  input  wire logic        double_request_mode,
  input  wire logic        combined_request,
  input  wire logic        transmit_request,
  input  wire logic        receive_request,
  input  wire logic [7:0]  interrupt_vector_reg,
  input  wire logic [7:0]  host_read_data,
  // Decoded host access
  output logic             host_select,
  output logic             host_read,
  output logic             host_write,
  output logic [2:0]       host_reg_addr,
  output logic [7:0]       host_write_data,
  output logic             vector_read,
  output logic             iface_reset
);

  // Configuration registers
  logic [15:0] pin_config_ff;
  logic [15:0] pin_dir_ff;
  logic [15:0] pin_value_ff;
  logic [7:0]  win_base_ff;
  logic [7:0]  addr_latch_ff;

  // Registered outputs
  logic [15:0] core_rdata_ff;
  logic [15:0] pin_out_ff;
  logic [15:0] pin_oe_n_ff;
  logic        host_select_ff;
  logic        host_read_ff;
  logic        host_write_ff;
  logic [2:0]  host_reg_addr_ff;
  logic [7:0]  host_write_data_ff;
  logic        vector_read_ff;
  logic        iface_reset_ff;

  // Next values
  logic [15:0] nxt_pin_out;
  logic [15:0] nxt_pin_oe_n;
  logic [15:0] nxt_core_rdata;

  // Decoded configuration
  logic gpio_en;
  logic a8_en;
  logic a9_en;
  logic sel_en;
  logic req_en;
  logic ack_en;
  logic port_en;
  logic req_od;
  logic ds_pol;
  logic as_pol;
  logic muxed;
  logic dual_stb;
  logic sel_pol;
  logic req_pol;
  logic ack_pol;

  // Pin roles and decoded pin levels
  logic [15:0] gpio_mode;
  logic [15:0] gpio_out;
  logic [15:0] gpio_oe_n;
  logic [15:0] gpio_read;
  logic        ack_is_input;
  logic        ds_act;
  logic        rd_line_act;
  logic        as_act;
  logic        cs_act;
  logic        ack_act;
  logic [2:0]  addr_hi;
  logic        base_match;
  logic        sel_int;
  logic        rd_stb;
  logic        wr_stb;
  logic        access;
  logic [2:0]  reg_addr;
  logic        drive_data;
  logic [7:0]  data_drive;
  logic        req_lvl_a;
  logic        req_lvl_b;

  assign gpio_en  = pin_config_ff[B_GPIO_EN];
  assign a8_en    = pin_config_ff[B_A8_EN];
  assign a9_en    = pin_config_ff[B_A9_EN];
  assign sel_en   = pin_config_ff[B_SEL_EN];
  assign req_en   = pin_config_ff[B_REQ_EN];
  assign ack_en   = pin_config_ff[B_ACK_EN];
  assign port_en  = pin_config_ff[B_PORT_EN];
  assign req_od   = pin_config_ff[B_REQ_OD];
  assign ds_pol   = pin_config_ff[B_DS_POL];
  assign as_pol   = pin_config_ff[B_AS_POL];
  assign muxed    = pin_config_ff[B_MUXED];
  assign dual_stb = pin_config_ff[B_DUAL_STB];
  assign sel_pol  = pin_config_ff[B_SEL_POL];
  assign req_pol  = pin_config_ff[B_REQ_POL];
  assign ack_pol  = pin_config_ff[B_ACK_POL];

  // Register writes; mode bits are trusted to change only while disabled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_config_ff <= PIN_CONFIG_RST;
      pin_dir_ff    <= PIN_DIR_RST;
      pin_value_ff  <= PIN_VALUE_RST;
      win_base_ff   <= WIN_BASE_RST;
    end else if (core_wr) begin
      unique case (core_addr)
        OFS_PIN_CONFIG: pin_config_ff <= core_wdata & PIN_CONFIG_WMASK;
        OFS_WIN_BASE:   win_base_ff   <= core_wdata[7:0];
        OFS_PIN_DIR:    pin_dir_ff    <= core_wdata;
        OFS_PIN_VALUE:  pin_value_ff  <= core_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    nxt_core_rdata = core_rdata_ff;
    if (core_rd) begin
      unique case (core_addr)
        OFS_PIN_CONFIG: nxt_core_rdata = pin_config_ff & PIN_CONFIG_WMASK;
        OFS_WIN_BASE:   nxt_core_rdata = {8'h00, win_base_ff};
        OFS_PIN_DIR:    nxt_core_rdata = pin_dir_ff;
        OFS_PIN_VALUE:  nxt_core_rdata = gpio_read;
        default:        nxt_core_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core_rdata_ff <= 16'h0000;
    end else begin
      core_rdata_ff <= nxt_core_rdata;
    end
  end

  // Acknowledge is an input only in single-request mode with both enables
  assign ack_is_input = port_en & req_en & ack_en & ~double_request_mode;

  // Pin roles: a set bit hands the pin to the general-purpose cell
  always_comb begin
    gpio_mode = 16'hFFFF;
    if (port_en) begin
      gpio_mode[P_DATA_HI:P_DATA_LO] = 8'h00;
      gpio_mode[P_ADDR0]  = 1'b0;
      gpio_mode[P_ADDR1]  = muxed & ~a8_en;
      gpio_mode[P_ADDR2]  = muxed & ~a9_en;
      gpio_mode[P_SELECT] = ~sel_en;
      gpio_mode[P_RW]     = 1'b0;
      gpio_mode[P_DS]     = 1'b0;
      gpio_mode[P_REQ]    = ~req_en;
      gpio_mode[P_ACK]    = ~(req_en & (double_request_mode | ack_en));
    end
  end

  // One general-purpose cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_cell
      pin_gpio_cell u_cell (
        .gpio_mode   (gpio_mode[gi]),
        .gpio_enable (gpio_en),
        .direction   (pin_dir_ff[gi]),
        .value       (pin_value_ff[gi]),
        .pin_in      (pin_in[gi]),
        .pin_out     (gpio_out[gi]),
        .pin_oe_n    (gpio_oe_n[gi]),
        .read_bit    (gpio_read[gi])
      );
    end
  endgenerate

  // Active levels of the incoming strobes and selects
  assign ds_act      = pin_in[P_DS] ~^ ds_pol;
  assign rd_line_act = pin_in[P_RW] ~^ ds_pol;
  assign as_act      = pin_in[P_ADDR0] ~^ as_pol;
  assign cs_act      = pin_in[P_SELECT] ~^ sel_pol;
  assign ack_act     = ack_is_input & (pin_in[P_ACK] ~^ ack_pol);

  // Address latch follows the bus while the address strobe is active
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_latch_ff <= 8'h00;
    end else if (!port_en) begin
      addr_latch_ff <= 8'h00;
    end else if (muxed && as_act) begin
      addr_latch_ff <= pin_in[P_DATA_HI:P_DATA_LO];
    end
  end

  // Upper address lines count only where their pin is given to the bus
  assign addr_hi = {sel_en & pin_in[P_SELECT],
                    a9_en & pin_in[P_ADDR2],
                    a8_en & pin_in[P_ADDR1]};
  assign base_match = ({addr_hi, addr_latch_ff[7:3]} == win_base_ff);

  // Chip select: self select when multiplexed, else the select pin, or always selected with bit 3 clear
  always_comb begin
    if (muxed) begin
      sel_int = base_match;
    end else if (sel_en) begin
      sel_int = cs_act;
    end else begin
      sel_int = 1'b1;
    end
  end

  // Read and write strobes from one strobe or two
  always_comb begin
    if (dual_stb) begin
      rd_stb = rd_line_act;
      wr_stb = ds_act;
    end else begin
      rd_stb = ds_act & pin_in[P_RW];
      wr_stb = ds_act & ~pin_in[P_RW];
    end
  end

  // Select only takes effect with a data strobe, so address glitches are harmless
  assign access = port_en & sel_int & (rd_stb | wr_stb);

  // Register address from the latch or straight from the pins
  assign reg_addr = muxed ? addr_latch_ff[2:0]
                          : {pin_in[P_ADDR2], pin_in[P_ADDR1], pin_in[P_ADDR0]};

  // Data pins carry the vector during acknowledge, else read data
  assign drive_data = ack_act | (access & rd_stb);
  assign data_drive = ack_act ? interrupt_vector_reg : host_read_data;

  // Request levels after polarity
  assign req_lvl_a = (double_request_mode ? transmit_request : combined_request)
                     ~^ req_pol;
  assign req_lvl_b = receive_request ~^ req_pol;

  // Pin drive: general pins from their cells, host pins by role
  always_comb begin
    nxt_pin_out  = gpio_out;
    nxt_pin_oe_n = gpio_oe_n;
    if (port_en) begin
      nxt_pin_out[P_DATA_HI:P_DATA_LO]  = data_drive;
      nxt_pin_oe_n[P_DATA_HI:P_DATA_LO] = drive_data ? 8'h00 : 8'hFF;
      nxt_pin_oe_n[P_ADDR0] = 1'b1;
      nxt_pin_oe_n[P_RW]    = 1'b1;
      nxt_pin_oe_n[P_DS]    = 1'b1;
      if (!gpio_mode[P_ADDR1]) begin
        nxt_pin_oe_n[P_ADDR1] = 1'b1;
      end
      if (!gpio_mode[P_ADDR2]) begin
        nxt_pin_oe_n[P_ADDR2] = 1'b1;
      end
      if (!gpio_mode[P_SELECT]) begin
        nxt_pin_oe_n[P_SELECT] = 1'b1;
      end
      if (req_en) begin
        // Open drain only ever pulls low, so the wire needs a pull-up
        nxt_pin_out[P_REQ]  = req_od ? 1'b0 : req_lvl_a;
        nxt_pin_oe_n[P_REQ] = req_od ? req_lvl_a : 1'b0;
        if (double_request_mode) begin
          nxt_pin_out[P_ACK]  = req_od ? 1'b0 : req_lvl_b;
          nxt_pin_oe_n[P_ACK] = req_od ? req_lvl_b : 1'b0;
        end else if (ack_en) begin
          nxt_pin_oe_n[P_ACK] = 1'b1;
        end
      end
    end
  end

  // Pin outputs are registered so the pads never see decode glitches
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_out_ff  <= 16'h0000;
      pin_oe_n_ff <= 16'hFFFF;
    end else begin
      pin_out_ff  <= nxt_pin_out;
      pin_oe_n_ff <= nxt_pin_oe_n;
    end
  end

  // Decoded access towards the interface registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      host_select_ff     <= 1'b0;
      host_read_ff       <= 1'b0;
      host_write_ff      <= 1'b0;
      host_reg_addr_ff   <= 3'h0;
      host_write_data_ff <= 8'h00;
      vector_read_ff     <= 1'b0;
    end else begin
      host_select_ff     <= access;
      host_read_ff       <= access & rd_stb;
      host_write_ff      <= access & wr_stb;
      host_reg_addr_ff   <= reg_addr;
      host_write_data_ff <= pin_in[P_DATA_HI:P_DATA_LO];
      vector_read_ff     <= ack_act;
    end
  end

  // Interface held in reset while the port is disabled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      iface_reset_ff <= 1'b1;
    end else begin
      iface_reset_ff <= ~port_en;
    end
  end

  assign core_rdata      = core_rdata_ff;
  assign pin_out         = pin_out_ff;
  assign pin_oe_n        = pin_oe_n_ff;
  assign host_select     = host_select_ff;
  assign host_read       = host_read_ff;
  assign host_write      = host_write_ff;
  assign host_reg_addr   = host_reg_addr_ff;
  assign host_write_data = host_write_data_ff;
  assign vector_read     = vector_read_ff;
  assign iface_reset     = iface_reset_ff;

endmodule
`default_nettype wire

// *** inc/host_port_pkg.sv ***
package host_port_pkg;
  // Core-side register addresses
  localparam logic [23:0] OFS_PIN_CONFIG = 24'hFFFFC4;
  localparam logic [23:0] OFS_WIN_BASE   = 24'hFFFFC5;
  localparam logic [23:0] OFS_PIN_DIR    = 24'hFFFFC8;
  localparam logic [23:0] OFS_PIN_VALUE  = 24'hFFFFC9;

  // Port control field positions
  localparam int B_GPIO_EN    = 0;
  localparam int B_A8_EN      = 1;
  localparam int B_A9_EN      = 2;
  localparam int B_SEL_EN     = 3;
  localparam int B_REQ_EN     = 4;
  localparam int B_ACK_EN     = 5;
  localparam int B_PORT_EN    = 6;
  localparam int B_REQ_OD     = 8;
  localparam int B_DS_POL     = 9;
  localparam int B_AS_POL     = 10;
  localparam int B_MUXED      = 11;
  localparam int B_DUAL_STB   = 12;
  localparam int B_SEL_POL    = 13;
  localparam int B_REQ_POL    = 14;
  localparam int B_ACK_POL    = 15;

  // Writable bits of each register
  localparam logic [15:0] PIN_CONFIG_WMASK = 16'hFF7F;
  localparam logic [15:0] WIN_BASE_WMASK   = 16'h00FF;

  // Reset values
  localparam logic [15:0] PIN_CONFIG_RST = 16'h0000;
  localparam logic [15:0] PIN_DIR_RST    = 16'h0000;
  localparam logic [15:0] PIN_VALUE_RST  = 16'h0000;
  localparam logic [7:0]  WIN_BASE_RST   = 8'h80;

  // Port pin positions
  localparam int P_DATA_LO = 0;
  localparam int P_DATA_HI = 7;
  localparam int P_ADDR0   = 8;
  localparam int P_ADDR1   = 9;
  localparam int P_ADDR2   = 10;
  localparam int P_SELECT  = 11;
  localparam int P_RW      = 12;
  localparam int P_DS      = 13;
  localparam int P_REQ     = 14;
  localparam int P_ACK     = 15;
  localparam int NUM_PINS  = 16;
endpackage

// *** hw/pin_gpio_cell.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_gpio_cell (
  // Configuration
  input  wire logic gpio_mode,
  input  wire logic gpio_enable,
  input  wire logic direction,
  input  wire logic value,
  // Pin side
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_n,
  // Read-back
  output logic      read_bit
);
  logic live;

  // A general pin only works while the general-pin enable is on
  assign live     = gpio_mode & gpio_enable;
  assign pin_out  = value;
  assign pin_oe_n = ~(live & direction);

  // Outputs read back what was written; a dead input reads zero
  assign read_bit = direction ? value : (live & pin_in);
endmodule
`default_nettype wire

// *** verif/host_port_pin_and_bus_config_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_and_bus_config_checker
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // Core register port
  input wire logic [23:0] core_addr,
  input wire logic        core_wr,
  input wire logic        core_rd,
  input wire logic [15:0] core_wdata,
  input wire logic [15:0] core_rdata,
  // Pins and requests
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic        double_request_mode,
  input wire logic        combined_request,
  input wire logic [7:0]  interrupt_vector_reg,
  // Decoded host access
  input wire logic        host_select,
  input wire logic        host_read,
  input wire logic        host_write,
  input wire logic        vector_read,
  input wire logic        iface_reset
);
  logic [15:0] cfg;
  logic [15:0] dir;
  logic [15:0] val;
  logic [47:0] prev;
  logic        steady;
  logic        req_on;
  // Shadow of the core writes, so pin checks know the settings
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg <= PIN_CONFIG_RST;
      dir <= PIN_DIR_RST;
      val <= PIN_VALUE_RST;
    end else if (core_wr) begin
      if (core_addr == OFS_PIN_CONFIG) cfg <= core_wdata & PIN_CONFIG_WMASK;
      if (core_addr == OFS_PIN_DIR) dir <= core_wdata;
      if (core_addr == OFS_PIN_VALUE) val <= core_wdata;
    end
  end
  // Pins lag a settings write by a cycle, so checks wait until it settles
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) prev <= {PIN_CONFIG_RST, PIN_DIR_RST, PIN_VALUE_RST};
    else prev <= {cfg, dir, val};
  end
  assign steady = prev == {cfg, dir, val};
  assign req_on = steady && cfg[B_PORT_EN] && cfg[B_REQ_EN];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  iface_held_a: assert property (!cfg[B_PORT_EN] && steady |-> iface_reset)
    else $error("interface not held while port disabled");
  iface_run_a: assert property (cfg[B_PORT_EN] && steady |-> !iface_reset)
    else $error("interface held while port enabled");
  host_idle_a: assert property (!cfg[B_PORT_EN] && steady |->
    !(host_select || host_read || host_write || vector_read))
    else $error("host access while port disabled");
  cfg_read_a: assert property (core_rd && core_addr == OFS_PIN_CONFIG |=>
    core_rdata == $past(cfg) && !core_rdata[7])
    else $error("config read-back wrong");
  base_read_a: assert property (core_rd && core_addr == OFS_WIN_BASE |=>
    core_rdata[15:8] == 8'h00)
    else $error("base upper bits not zero");
  gpio_float_a: assert property (!cfg[B_GPIO_EN] && !cfg[B_PORT_EN] && steady |->
    pin_oe_n == 16'hFFFF)
    else $error("general pin driven while disabled");
  gpio_dir_a: assert property (cfg[B_GPIO_EN] && !cfg[B_PORT_EN] && steady |->
    pin_oe_n == ~dir && (pin_out & dir) == (val & dir))
    else $error("general pin direction or value wrong");
  access_sel_a: assert property (host_read || host_write |->
    host_select && !(host_read && host_write))
    else $error("access without select");
  vector_a: assert property (vector_read |->
    pin_oe_n[7:0] == 8'h00 && pin_out[7:0] == $past(interrupt_vector_reg))
    else $error("vector not on data pins");
  req_drive_a: assert property (req_on && !cfg[B_REQ_OD] &&
    !$past(double_request_mode) |->
    !pin_oe_n[14] && pin_out[14] == ($past(combined_request) == cfg[B_REQ_POL]))
    else $error("driven request level wrong");
  req_od_a: assert property (req_on && cfg[B_REQ_OD] &&
    !$past(double_request_mode) |->
    !pin_out[14] && pin_oe_n[14] == ($past(combined_request) == cfg[B_REQ_POL]))
    else $error("open drain request wrong");
  cover property (host_write);
  cover property (host_read && pin_oe_n[7:0] == 8'h00);
  cover property (vector_read);
endmodule
`default_nettype wire

// *** verif/host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // Clock
  input  wire logic        mclk,
  // Pins as the host sees them
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  output logic [15:0]      pin_in
);
  logic [15:0] drv = 16'h0000;
  logic [15:0] den = 16'h0000;
  logic        flt = 1'b0;
  // Undriven lines change each cycle so stale data never passes as real
  always @(posedge mclk) flt <= ~flt;
  // Device wins where it drives, then the host, else noise
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & den & drv)
                | (pin_oe_n & ~den & ({16{flt}} ^ 16'hA5C3));
  // Drive or release the masked lines
  task automatic put(input logic [15:0] m, input logic [15:0] v, input logic on);
    den = on ? (den | m) : (den & ~m);
    drv = (drv & ~m) | (v & m);
  endtask
  // Strobes inactive, data lines released
  task automatic idle(input logic asp, input logic dsp);
    @(negedge mclk);
    put(16'h3100, {2'b00, ~dsp, ~dsp, 3'b000, ~asp, 8'h00}, 1'b1);
    put(16'h00FF, 16'h0000, 1'b0);
  endtask
  // Address phase; strobe active for one cycle only
  task automatic addr_phase(input logic [10:0] a, input logic asp);
    @(negedge mclk);
    put(16'h0FFF, {4'h0, a[10:8], asp, a[7:0]}, 1'b1);
    @(negedge mclk);
    put(16'h0100, {7'h00, ~asp, 8'h00}, 1'b1);
  endtask
  // Data phase: strobe plus read/write line, or separate strobes
  task automatic strobe(input logic rd, input logic [7:0] wd, input logic dsp,
                        input logic dual);
    @(negedge mclk);
    put(16'h00FF, {8'h00, wd}, ~rd);
    put(16'h3000, {2'b00, dual ? (rd ? ~dsp : dsp) : dsp,
        dual ? (rd ? dsp : ~dsp) : rd, 12'h000}, 1'b1);
  endtask
endmodule
`default_nettype wire

// *** verif/host_port_pin_and_bus_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
bind host_port_pin_and_bus_config host_port_pin_and_bus_config_checker chk_i (
  .mclk, .resetn, .core_addr, .core_wr, .core_rd, .core_wdata, .core_rdata, .pin_out,
  .pin_oe_n, .double_request_mode, .combined_request, .interrupt_vector_reg,
  .host_select, .host_read, .host_write, .vector_read, .iface_reset);
module host_port_pin_and_bus_config_tb
  import host_port_pkg::*;
;
  // Core side and interface logic drives
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [23:0] core_addr = 24'h000000;
  logic        core_wr = 1'b0;
  logic        core_rd = 1'b0;
  logic [15:0] core_wdata = 16'h0000;
  logic        double_request_mode = 1'b0;
  logic        combined_request = 1'b0;
  logic        transmit_request = 1'b0;
  logic        receive_request = 1'b0;
  logic [7:0]  interrupt_vector_reg = 8'h00;
  logic [7:0]  host_read_data = 8'h00;
  logic [15:0] cur = 16'h0000;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;
  // Design outputs
  wire logic [15:0] core_rdata;
  wire logic [15:0] pin_in;
  wire logic [15:0] pin_out;
  wire logic [15:0] pin_oe_n;
  wire logic        host_select;
  wire logic        host_read;
  wire logic        host_write;
  wire logic [2:0]  host_reg_addr;
  wire logic [7:0]  host_write_data;
  wire logic        vector_read;
  wire logic        iface_reset;
  wire logic [5:0]  acc = {host_select, host_write, host_read, host_reg_addr};
  host_port_pin_and_bus_config dut (.mclk, .resetn, .core_addr, .core_wr, .core_rd,
    .core_wdata, .core_rdata, .pin_in, .pin_out, .pin_oe_n, .double_request_mode,
    .combined_request, .transmit_request, .receive_request, .interrupt_vector_reg,
    .host_read_data, .host_select, .host_read, .host_write, .host_reg_addr,
    .host_write_data, .vector_read, .iface_reset);
  host_bus_model host (.mclk, .pin_out, .pin_oe_n, .pin_in);
  initial forever #4 mclk = ~mclk;
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(negedge mclk);
    core_addr = a;
    core_wdata = d;
    core_wr = 1'b1;
    @(negedge mclk);
    core_wr = 1'b0;
  endtask
  task automatic rdc(input logic [23:0] a, input logic [15:0] e);
    @(negedge mclk);
    core_addr = a;
    core_rd = 1'b1;
    @(negedge mclk);
    core_rd = 1'b0;
    chk(core_rdata, e);
  endtask
  task automatic wait2;
    repeat (2) @(negedge mclk);
  endtask
  // Mode bits change only with the port off, and never with the enabling write
  task automatic cfgset(input logic [15:0] c);
    wr(OFS_PIN_CONFIG, cur & 16'hFFBF);
    wr(OFS_PIN_CONFIG, c & 16'hFFBF);
    wr(OFS_PIN_CONFIG, c);
    cur = c;
    wait2();
  endtask
  task automatic t_reset;
    chk(pin_oe_n, 16'hFFFF);
    chk(iface_reset, 1'b1);
    rdc(OFS_PIN_CONFIG, PIN_CONFIG_RST);
    rdc(OFS_WIN_BASE, {8'h00, WIN_BASE_RST});
    rdc(OFS_PIN_DIR, PIN_DIR_RST);
    rdc(24'hFFFFC6, 16'h0000);
    $display("reset values done");
  endtask
  task automatic t_regs;
    wr(OFS_PIN_CONFIG, 16'hFFBF);
    rdc(OFS_PIN_CONFIG, 16'hFF3F);
    wr(OFS_WIN_BASE, 16'hFFFF);
    rdc(OFS_WIN_BASE, 16'h00FF);
    wr(OFS_PIN_DIR, 16'hA5A5);
    rdc(OFS_PIN_DIR, 16'hA5A5);
    wr(OFS_PIN_CONFIG, 16'h0000);
    $display("register access done");
  endtask
  task automatic t_gpio;
    wr(OFS_PIN_DIR, 16'h00FF);
    wr(OFS_PIN_VALUE, 16'h5A3C);
    wr(OFS_PIN_CONFIG, 16'h0001);
    host.put(16'hFF00, 16'hB700, 1'b1);
    wait2();
    chk(pin_oe_n, 16'hFF00);
    chk(pin_out & 16'h00FF, 16'h003C);
    rdc(OFS_PIN_VALUE, 16'hB73C);
    wr(OFS_PIN_CONFIG, 16'h0000);
    wait2();
    chk(pin_oe_n, 16'hFFFF);
    rdc(OFS_PIN_VALUE, 16'h003C);
    host.put(16'hFF00, 16'h0000, 1'b0);
    $display("general pins done");
  endtask
  // Base A5 sits in host address bits 10..3; alt flips polarities and strobes
  task automatic t_mux(input logic alt);
    host.idle(alt, alt);
    wr(OFS_WIN_BASE, 16'h00A5);
    cfgset(alt ? 16'h1E4E : 16'h084E);
    chk(iface_reset, 1'b0);
    host.addr_phase(11'h52B, alt);
    host.strobe(1'b0, 8'h6E, alt, alt);
    wait2();
    chk(acc, 6'b110011);
    chk(host_write_data, 8'h6E);
    host.idle(alt, alt);
    host_read_data = 8'hC4;
    host.addr_phase(11'h52E, alt);
    host.strobe(1'b1, 8'h00, alt, alt);
    wait2();
    chk(acc, 6'b101110);
    chk(pin_in[7:0], 8'hC4);
    host.idle(alt, alt);
    host.addr_phase(11'h12B, alt);
    host.strobe(1'b0, 8'h11, alt, alt);
    wait2();
    chk(host_select, 1'b0);
    host.idle(alt, alt);
    cfgset(16'h0000);
    $display("multiplexed cycles done, variant %0d", alt);
  endtask
  task automatic t_nonmux;
    host.put(16'h3FFF, 16'h2D33, 1'b1);
    cfgset(16'h2048);
    host.put(16'h2000, 16'h0000, 1'b1);
    wait2();
    chk(acc, 6'b110101);
    host.put(16'h0800, 16'h0000, 1'b1);
    wait2();
    chk(host_select, 1'b0);
    // Same pins, select now active low: the low select pin must pick the port
    cfgset(16'h0048);
    chk(host_select, 1'b1);
    host.idle(1'b0, 1'b0);
    cfgset(16'h0000);
    $display("plain bus cycles done");
  endtask
  task automatic t_req;
    host.put(16'h8000, 16'h8000, 1'b1);
    cfgset(16'h0070);
    for (int i = 0; i < 2; i++) begin
      combined_request = i[0];
      wait2();
      chk({pin_oe_n[14], pin_out[14]}, {1'b0, ~i[0]});
    end
    interrupt_vector_reg = 8'h9D;
    host.put(16'h8000, 16'h0000, 1'b1);
    wait2();
    chk(vector_read, 1'b1);
    chk(pin_in[7:0], 8'h9D);
    // Acknowledge turned active high: the low pin is now idle
    cfgset(16'h8070);
    chk(vector_read, 1'b0);
    host.put(16'h8000, 16'h8000, 1'b1);
    wait2();
    chk(vector_read, 1'b1);
    chk(pin_in[7:0], 8'h9D);
    host.put(16'h8000, 16'h8000, 1'b1);
    cfgset(16'h4170);
    for (int i = 0; i < 2; i++) begin
      combined_request = i[0];
      wait2();
      chk({pin_oe_n[14], pin_out[14]}, {i[0], 1'b0});
    end
    double_request_mode = 1'b1;
    transmit_request = 1'b1;
    host.put(16'h8000, 16'h0000, 1'b0);
    wait2();
    chk({pin_oe_n[15:14], pin_out[15:14]}, 4'b0100);
    chk(vector_read, 1'b0);
    double_request_mode = 1'b0;
    host.put(16'h8000, 16'h8000, 1'b1);
    cfgset(16'h0000);
    $display("requests and acknowledge done");
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    t_reset();
    t_regs();
    t_gpio();
    t_mux(1'b0);
    t_mux(1'b1);
    t_nonmux();
    t_req();
    tally_and_finish();
  end
endmodule
`default_nettype wire
